// [pkg/eat_pkg.sv]
package eat_pkg;
	// timing and field constants for the acknowledge-terminated access block
	localparam int          CLK_MHZ          = 25;
	localparam int          TIMEOUT_CYCLES   = 1024;
	localparam int          TMO_W            = 11;
	localparam int          WSC_W            = 6;
	localparam logic [5:0]  WSC_EDGE_CODE    = 6'h3f;
	localparam int          DLY_W            = 4;
	localparam int          IGN_W            = 2;
	localparam logic [2:0]  IGN_BASE         = 3'h2;
	localparam int          CS_W             = 3;
	localparam logic [2:0]  CS_EDGE_ONLY     = 3'h5;
	localparam logic [2:0]  CS_SHARED_ACK    = 3'h4;
	localparam logic [10:0] TMO_RESET        = 11'h000;

	typedef enum {
		ST_IDLE,
		ST_SETUP,
		ST_IGNORE,
		ST_WAIT,
		ST_NEGATE
	} eat_state_t;
endpackage

// [pkg/eat_sync_if.sv]
`timescale 1ns/1ps
`default_nettype none
// carries the synchronised acknowledge level and its rising edge
interface eat_sync_if;
	logic ack_level;
	logic ack_rise;
	modport src (output ack_level, output ack_rise);
	modport dst (input ack_level, input ack_rise);
endinterface
`default_nettype wire

// [rtl/eat_ack_sync.sv]
`timescale 1ns/1ps
`default_nettype none
// two-flop synchroniser for the acknowledge pin plus a rise detector behind it
module eat_ack_sync (
	input  wire logic clk,
	input  wire logic nrst,
	input  wire logic ack_pin,
	eat_sync_if.src   sync
);
	logic meta_reg;
	logic stab_reg;
	logic prev_reg;

	// first flop feeds only the second; the edge detector looks at stable bits
	always_ff @(posedge clk) begin
		if (!nrst) begin
			meta_reg <= 1'b0;
			stab_reg <= 1'b0;
			prev_reg <= 1'b0;
		end else begin
			meta_reg <= ack_pin;
			stab_reg <= meta_reg;
			prev_reg <= stab_reg;
		end
	end

	assign sync.ack_level = stab_reg;
	assign sync.ack_rise  = stab_reg & ~prev_reg;
endmodule
`default_nettype wire

// [rtl/eat_ctrl.sv]
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - on an asynchronous access with acknowledge enabled, 1024 cycles without termination raise a bus error
// - two detection modes: rising edge, or level after an insensitivity period
// - edge mode ends the transfer on an acknowledge rising edge before time-out
// - edge detection is honoured only on chip select five
// - nonzero select delay lets back-to-back transfers wait for each new edge
// - level mode ignores acknowledge for 2 to 5 cycles from the ignore field
// - acknowledge high at first sample: finish with programmed wait states
// - acknowledge low at first sample: stall until high, within time-out
// - level mode pauses whenever acknowledge goes low, resumes once high
module eat_ctrl (
	input  wire logic                        CLK,
	input  wire logic                        NRST,
	input  wire logic                        REQ,
	input  wire logic [eat_pkg::CS_W-1:0]    CS_SEL,
	input  wire logic                        SYNC_MODE,
	input  wire logic                        ACK_GATE_ENABLE,
	input  wire logic                        EXTERNAL_WAIT_ENABLE,
	input  wire logic [eat_pkg::WSC_W-1:0]   WAIT_STATE_COUNT,
	input  wire logic [eat_pkg::DLY_W-1:0]   CHIP_SELECT_ASSERT_DELAY,
	input  wire logic [eat_pkg::DLY_W-1:0]   CHIP_SELECT_NEGATE_DELAY,
	input  wire logic [eat_pkg::IGN_W-1:0]   ACK_IGNORE_TIME,
	input  wire logic                        EXT_TRANSFER_ACK,
	output logic                             CS_ACTIVE,
	output logic                             DONE,
	output logic                             BUS_ERROR,
	output logic                             BUSY
);
	import eat_pkg::*;

	eat_sync_if sync_bus ();

	eat_state_t         state_reg;
	logic [TMO_W-1:0]   tmo_reg;
	logic [DLY_W-1:0]   dly_reg;
	logic [WSC_W-1:0]   ws_reg;
	logic               edge_mode_reg;
	logic               ack_mode_reg;
	logic               timeout;

	eat_ack_sync u_sync (
		.clk     (CLK),
		.nrst    (NRST),
		.ack_pin (EXT_TRANSFER_ACK),
		.sync    (sync_bus)
	);

	// level acknowledge and time-out only apply to asynchronous transfers; edge-mode acknowledge also applies to synchronous ones
	function automatic logic ack_used(input logic sync_bit, input logic ew, input logic ack_gate_enable);
		return !sync_bit && (ew || ack_gate_enable);
	endfunction

	// insensitivity length: field 0..3 maps to 2..5 cycles
	function automatic logic [DLY_W-1:0] ignore_len(input logic [IGN_W-1:0] f);
		return DLY_W'({1'b0, IGN_BASE} + {2'b00, f});
	endfunction

	assign timeout = ack_mode_reg && (tmo_reg == TMO_W'(TIMEOUT_CYCLES - 1));

	// latch the mode at the start of each access
	always_ff @(posedge CLK) begin
		if (!NRST) begin
			edge_mode_reg <= 1'b0;
			ack_mode_reg  <= 1'b0;
		end else if (state_reg == ST_IDLE && REQ) begin
			// edge detection only counts on select five; elsewhere gating is ignored
			edge_mode_reg <= ACK_GATE_ENABLE && (CS_SEL == CS_EDGE_ONLY);
			ack_mode_reg  <= ack_used(SYNC_MODE, EXTERNAL_WAIT_ENABLE,
				ACK_GATE_ENABLE && (CS_SEL == CS_EDGE_ONLY));
		end
	end

	// time-out counter runs from select assertion until termination
	always_ff @(posedge CLK) begin
		if (!NRST) begin
			tmo_reg <= TMO_RESET;
		end else if (state_reg == ST_IDLE || state_reg == ST_NEGATE) begin
			tmo_reg <= TMO_RESET;
		end else begin
			tmo_reg <= tmo_reg + TMO_W'(1);
		end
	end

	// access sequencer
	always_ff @(posedge CLK) begin
		if (!NRST) begin
			state_reg <= ST_IDLE;
			dly_reg   <= '0;
			ws_reg    <= '0;
		end else begin
			case (state_reg)
				ST_IDLE: begin
					if (REQ) begin
						state_reg <= ST_SETUP;
						dly_reg   <= CHIP_SELECT_ASSERT_DELAY;
						ws_reg    <= WAIT_STATE_COUNT;
					end
				end
				ST_SETUP: begin
					if (dly_reg != '0) begin
						dly_reg <= dly_reg - DLY_W'(1);
					end else if (ack_mode_reg && !edge_mode_reg) begin
						state_reg <= ST_IGNORE;
						dly_reg   <= ignore_len(ACK_IGNORE_TIME);
					end else begin
						state_reg <= ST_WAIT;
					end
				end
				ST_IGNORE: begin
					// acknowledge not looked at here
					if (timeout) begin
						state_reg <= ST_NEGATE;
						dly_reg   <= CHIP_SELECT_NEGATE_DELAY;
					end else if (dly_reg <= DLY_W'(1)) begin
						state_reg <= ST_WAIT;
					end else begin
						dly_reg <= dly_reg - DLY_W'(1);
					end
				end
				ST_WAIT: begin
					if (timeout) begin
						state_reg <= ST_NEGATE;
						dly_reg   <= CHIP_SELECT_NEGATE_DELAY;
					end else if (edge_mode_reg) begin
						// in edge mode the wait count is ignored; any value waits for the edge alone
						if (sync_bus.ack_rise) begin
							state_reg <= ST_NEGATE;
							dly_reg   <= CHIP_SELECT_NEGATE_DELAY;
						end
					end else if (ack_mode_reg && !sync_bus.ack_level) begin
						state_reg <= ST_WAIT;
					end else if (ws_reg == '0) begin
						state_reg <= ST_NEGATE;
						dly_reg   <= CHIP_SELECT_NEGATE_DELAY;
					end else begin
						ws_reg <= ws_reg - WSC_W'(1);
					end
				end
				ST_NEGATE: begin
					// the negate gap forces the next edge to be a fresh one
					if (dly_reg != '0) begin
						dly_reg <= dly_reg - DLY_W'(1);
					end else begin
						state_reg <= ST_IDLE;
					end
				end
				default: begin
					state_reg <= ST_IDLE;
				end
			endcase
		end
	end

	// select line: up from the accepting edge until the edge that ends the wait phase;
	// it mirrors the sequencer's exit terms so the pin drops with the state change
	always_ff @(posedge CLK) begin
		if (!NRST) begin
			CS_ACTIVE <= 1'b0;
		end else begin
			CS_ACTIVE <= (state_reg == ST_IDLE && REQ) || state_reg == ST_SETUP
				|| state_reg == ST_IGNORE
				|| (state_reg == ST_WAIT && !(timeout
				|| (edge_mode_reg && sync_bus.ack_rise)
				|| (!edge_mode_reg && (!ack_mode_reg || sync_bus.ack_level)
				&& ws_reg == '0)));
		end
	end

	// done pulse: one cycle, on the edge that leaves the negate gap, also after an error
	always_ff @(posedge CLK) begin
		if (!NRST) begin
			DONE <= 1'b0;
		end else begin
			DONE <= state_reg == ST_NEGATE && dly_reg == '0;
		end
	end

	// error pulse: one cycle on time-out; the access still runs its negate gap afterwards
	always_ff @(posedge CLK) begin
		if (!NRST) begin
			BUS_ERROR <= 1'b0;
		end else begin
			BUS_ERROR <= (state_reg == ST_WAIT || state_reg == ST_IGNORE) && timeout;
		end
	end

	// busy level: falls with the done pulse so a held request is taken one cycle later
	always_ff @(posedge CLK) begin
		if (!NRST) begin
			BUSY <= 1'b0;
		end else begin
			BUSY <= !(state_reg == ST_IDLE && !REQ)
				&& !(state_reg == ST_NEGATE && dly_reg == '0);
		end
	end
endmodule
`default_nettype wire

// [bench/eat_ack_dev.sv]
`timescale 1ns/1ps
`default_nettype none
// far-side device: raises acknowledge a set number of select cycles after selection
module eat_ack_dev (
	input  wire logic        clk,
	input  wire logic        cs_active,
	input  wire logic [10:0] lag,
	output logic             ack
);
	logic [10:0] cnt_reg;
	// a lag of 11'h7ff never answers; deselected, the line is pulled low, so every access sees a new rise
	always_ff @(posedge clk) begin
		cnt_reg <= (cs_active === 1'b1) ? cnt_reg + 11'h001 : 11'h000;
		ack     <= (cs_active === 1'b1) && (lag != 11'h7ff) && (cnt_reg >= lag);
	end
endmodule
`default_nettype wire

// [bench/eat_checker.sv]
`timescale 1ns/1ps
`default_nettype none
module eat_checker (
	input wire logic CLK, NRST, REQ, SYNC_MODE, EXTERNAL_WAIT_ENABLE, EXT_TRANSFER_ACK,
	input wire logic CS_ACTIVE, DONE, BUS_ERROR, BUSY
);
	logic [10:0] busy_cnt;
	default clocking @(posedge CLK); endclocking
	default disable iff (!NRST);
	// length of the current access; saturates so a hang cannot wrap back to a small value
	always_ff @(posedge CLK) begin
		busy_cnt <= (!NRST || !BUSY) ? 11'h000 : busy_cnt + {10'h000, busy_cnt != 11'h7ff};
	end
	done_one_cycle_a: assert property (DONE |=> !DONE) else $error("done too long");
	err_one_cycle_a: assert property (BUS_ERROR |=> !BUS_ERROR) else $error("error too long");
	err_then_done_a: assert property (BUS_ERROR |-> ##[1:20] DONE) else $error("no done");
	done_frees_a: assert property (DONE |-> !BUSY && !CS_ACTIVE && $past(BUSY))
		else $error("bus not freed");
	req_taken_a: assert property (!BUSY && REQ |=> BUSY && CS_ACTIVE) else $error("req lost");
	level_needs_ack_a: assert property ($fell(CS_ACTIVE) && EXTERNAL_WAIT_ENABLE && !SYNC_MODE
		&& busy_cnt < 11'h3f0 |-> $past(EXT_TRANSFER_ACK, 2) || $past(EXT_TRANSFER_ACK, 3)
		|| $past(EXT_TRANSFER_ACK, 4) || $past(EXT_TRANSFER_ACK, 5)) else $error("ended without ack");
	access_bounded_a: assert property (busy_cnt < 11'h415) else $error("access hangs");
	err_at_limit_a: assert property (BUS_ERROR |-> busy_cnt >= 11'h3fc && busy_cnt <= 11'h406)
		else $error("time-out off");
	sync_no_err_a: assert property (SYNC_MODE |-> !BUS_ERROR) else $error("sync timed out");
	cover property (BUS_ERROR);
	cover property (DONE);
	cover property ($fell(CS_ACTIVE) && EXTERNAL_WAIT_ENABLE);
endmodule
bind eat_ctrl eat_checker chk (.CLK, .NRST, .REQ, .SYNC_MODE, .EXTERNAL_WAIT_ENABLE,
	.EXT_TRANSFER_ACK, .CS_ACTIVE, .DONE, .BUS_ERROR, .BUSY);
`default_nettype wire

// [bench/test_ext_bus_ack_termination.sv]
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin fails++; $display("CHECK FAILED %0t got %0h want %0h", $time, a, b); end end
module test_ext_bus_ack_termination;
	import eat_pkg::*;
	typedef struct packed {
		logic ew; logic ack_gate_enable; logic [2:0] cs; logic sy; logic [5:0] wait_state_count; logic [3:0] chip_select_assert_delay;
		logic [3:0] chip_select_negate_delay; logic [1:0] ign; logic [10:0] lag; logic err; logic [10:0] lo;
	} eat_row_t;
	logic clk = 1'b0, nrst = 1'b0, req = 1'b0, sy = 1'b0, ack_gate_enable = 1'b0, ew = 1'b0, ack, err;
	logic [2:0] cs = 3'h0;
	logic [5:0] wait_state_count = 6'h00;
	logic [3:0] chip_select_assert_delay = 4'h0, chip_select_negate_delay = 4'h0;
	logic [1:0] ign = 2'h0;
	logic [10:0] lag = 11'h000;
	logic cs_act, done, berr, busy;
	int fails = 0, compares = 0, cyc;
	// fields: ew age cs sync wsc csa csn ign lag | error expected, least cycles
	eat_row_t rows [0:6] = '{
		'{1'b1, 1'b0, 3'h1, 1'b0, 6'h02, 4'h1, 4'h1, 2'h0, 11'h000, 1'b0, 11'h003},
		'{1'b1, 1'b0, 3'h2, 1'b0, 6'h03, 4'h2, 4'h2, 2'h3, 11'h028, 1'b0, 11'h028},
		'{1'b0, 1'b1, 3'h5, 1'b0, 6'h3f, 4'h1, 4'h1, 2'h0, 11'h00a, 1'b0, 11'h00a},
		'{1'b0, 1'b1, 3'h3, 1'b0, 6'h03, 4'h1, 4'h1, 2'h0, 11'h7ff, 1'b0, 11'h003},
		'{1'b1, 1'b0, 3'h1, 1'b1, 6'h03, 4'h1, 4'h1, 2'h0, 11'h7ff, 1'b0, 11'h003},
		'{1'b1, 1'b0, 3'h6, 1'b0, 6'h02, 4'h1, 4'h2, 2'h1, 11'h7ff, 1'b1, 11'h3fc},
		'{1'b0, 1'b1, 3'h5, 1'b0, 6'h3f, 4'h1, 4'h1, 2'h0, 11'h7ff, 1'b1, 11'h3fc}};
	eat_ctrl dut (.CLK(clk), .NRST(nrst), .REQ(req), .CS_SEL(cs), .SYNC_MODE(sy),
		.ACK_GATE_ENABLE(ack_gate_enable), .EXTERNAL_WAIT_ENABLE(ew), .WAIT_STATE_COUNT(wait_state_count),
		.CHIP_SELECT_ASSERT_DELAY(chip_select_assert_delay), .CHIP_SELECT_NEGATE_DELAY(chip_select_negate_delay), .ACK_IGNORE_TIME(ign),
		.EXT_TRANSFER_ACK(ack), .CS_ACTIVE(cs_act), .DONE(done), .BUS_ERROR(berr), .BUSY(busy));
	eat_ack_dev dev (.clk(clk), .cs_active(cs_act), .lag(lag), .ack(ack));
	initial forever #20 clk = ~clk;
	// watchdog sized for two time-outs plus the short accesses
	initial begin
		#300000;
		fails++;
		end_sim;
	end
	task automatic end_sim;
		$display("compares %0d fails %0d", compares, fails);
		if (fails == 0 && compares > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	// follows one access to its done pulse, catching any error pulse on the way
	task automatic wait_done(input logic [10:0] lo, input logic xerr);
		err = 1'b0;
		cyc = 0;
		do begin
			@(posedge clk) #1;
			cyc++;
			err = err | berr;
		end while (!done && cyc < 1200);
		`CHK(done, 1'b1)
		`CHK(err, xerr)
		`CHK(cyc >= lo, 1'b1)
	endtask
	initial begin
		repeat (5) @(posedge clk);
		#1 nrst = 1'b1;
		foreach (rows[i]) begin
			@(posedge clk) #1;
			{ew, ack_gate_enable, cs, sy, wait_state_count, chip_select_assert_delay, chip_select_negate_delay, ign, lag} = rows[i][44:12];
			req = 1'b1;
			@(posedge clk) #1;
			req = 1'b0;
			wait_done(rows[i].lo, rows[i].err);
		end
		// request held across two edge-mode accesses: each must wait for its own rise
		{ew, ack_gate_enable, cs, wait_state_count, lag} = {1'b0, 1'b1, 3'h5, 6'h3f, 11'h005};
		req = 1'b1;
		wait_done(11'h005, 1'b0);
		wait_done(11'h005, 1'b0);
		req = 1'b0;
		// reset in mid-access drops every output
		@(posedge clk) #1 req = 1'b1;
		repeat (4) @(posedge clk);
		#1 nrst = 1'b0;
		req = 1'b0;
		repeat (2) @(posedge clk);
		#1 `CHK({busy, done, berr, cs_act}, 4'h0)
		nrst = 1'b1;
		@(posedge clk) #1;
		`CHK({busy, done, berr, cs_act}, 4'h0)
		repeat (2) @(posedge clk);
		end_sim;
	end
endmodule
`default_nettype wire
